// ### hw/wdt_top.sv
// Purpose: Watchdog timer reached through an index/data I/O port pair.
// Assumes: ISA-style strobes from pins, held several core clocks.
// Notes: Time-out outputs stay high until a refresh, a disable, a reset or a rewrite that clears their action bit.
`timescale 1ns/1ps
`include "wdt_consts.svh"
module wdt_top #(
    parameter int CLK_HZ = `WDT_CORE_CLK_HZ,
    parameter int TICK_HZ = `WDT_TICK_HZ,
    parameter int CW = `WDT_COUNT_WIDTH
) (
    input wire logic CORE_CLK_I, // Core clock, 10 MHz
    input wire logic RST_N_I, // Async reset, active low
    input wire logic [9:0] IO_ADDR_I, // I/O address
    input wire logic [7:0] IO_WDATA_I, // Write data from host
    input wire logic IO_WR_N_I, // I/O write strobe, active low
    input wire logic IO_RD_N_I, // I/O read strobe, active low
    output logic [7:0] IO_RDATA_O, // Read data to host
    output logic IO_RDATA_OE_O, // Drive enable of read data
    output logic WDT_RESET_O, // Time-out system reset request
    output logic WDT_IRQ_O, // Time-out interrupt request
    output logic WDT_NMI_O // Time-out non-maskable interrupt
);
    // -----------------------------------------------------------------------
    // Pin synchronisers
    // -----------------------------------------------------------------------
    logic [9:0] addr_s1_reg, addr_s2_reg;
    logic [7:0] data_s1_reg, data_s2_reg;
    logic wr_s1_reg, wr_s2_reg, wr_s3_reg;
    logic rd_s1_reg, rd_s2_reg;
    logic wr_pulse;

    // The edge detector looks at the second and third stage only.
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            addr_s1_reg <= 10'h000;
            addr_s2_reg <= 10'h000;
            data_s1_reg <= 8'h00;
            data_s2_reg <= 8'h00;
            wr_s1_reg <= 1'b0;
            wr_s2_reg <= 1'b0;
            wr_s3_reg <= 1'b0;
            rd_s1_reg <= 1'b0;
            rd_s2_reg <= 1'b0;
        end else begin
            addr_s1_reg <= IO_ADDR_I;
            addr_s2_reg <= addr_s1_reg;
            data_s1_reg <= IO_WDATA_I;
            data_s2_reg <= data_s1_reg;
            wr_s1_reg <= ~IO_WR_N_I;
            wr_s2_reg <= wr_s1_reg;
            wr_s3_reg <= wr_s2_reg;
            rd_s1_reg <= ~IO_RD_N_I;
            rd_s2_reg <= rd_s1_reg;
        end
    end

    assign wr_pulse = wr_s2_reg & ~wr_s3_reg;

    // -----------------------------------------------------------------------
    // Tick source
    // -----------------------------------------------------------------------
    logic tick;

    wdt_tick_gen #(
        .CLK_HZ(CLK_HZ),
        .TICK_HZ(TICK_HZ)
    ) u_tick (
        .clk_i(CORE_CLK_I),
        .rst_n_i(RST_N_I),
        .tick_o(tick)
    );

    // -----------------------------------------------------------------------
    // Register file
    // -----------------------------------------------------------------------
    logic [7:0] index_reg, index_next;
    logic [7:0] unlock_reg, unlock_next;
    logic [7:0] enable_reg, enable_next;
    logic [7:0] action_reg, action_next;
    logic [CW-1:0] preset_reg, preset_next;
    logic [7:0] rdata_reg, rdata_next;
    logic refresh;
    logic hit_index, hit_data, wr_data, unlocked;

    function automatic logic [7:0] read_mux(
        input logic [7:0] idx,
        input logic [7:0] unl,
        input logic [7:0] ena,
        input logic [7:0] act,
        input logic [CW-1:0] pre
    );
        case (idx)
            `WDT_IDX_UNLOCK: read_mux = unl;
            `WDT_IDX_ENABLE: read_mux = ena;
            `WDT_IDX_ACTION: read_mux = act;
            `WDT_IDX_CNT_LO: read_mux = pre[7:0];
            `WDT_IDX_CNT_MID: read_mux = pre[15:8];
            `WDT_IDX_CNT_HI: read_mux = pre[23:16];
            default: read_mux = 8'h00;
        endcase
    endfunction

    assign hit_index = (addr_s2_reg == `WDT_IO_INDEX_ADDR);
    assign hit_data = (addr_s2_reg == `WDT_IO_DATA_ADDR);
    assign wr_data = wr_pulse & hit_data;
    assign unlocked = unlock_reg[`WDT_UNLOCK_BIT];

    always_comb begin
        index_next = index_reg;
        unlock_next = unlock_reg;
        enable_next = enable_reg;
        action_next = action_reg;
        preset_next = preset_reg;
        refresh = 1'b0;
        if (wr_pulse && hit_index) begin
            index_next = data_s2_reg;
        end
        if (wr_data) begin
            case (index_reg)
                `WDT_IDX_UNLOCK: begin
                    unlock_next = data_s2_reg;
                end
                `WDT_IDX_ENABLE: begin
                    if (unlocked) begin
                        enable_next = data_s2_reg;
                        refresh = 1'b1;
                    end
                end
                `WDT_IDX_ACTION: begin
                    if (unlocked) begin
                        action_next = data_s2_reg;
                    end
                end
                `WDT_IDX_CNT_LO: begin
                    if (unlocked) begin
                        preset_next[7:0] = data_s2_reg;
                        refresh = 1'b1;
                    end
                end
                `WDT_IDX_CNT_MID: begin
                    if (unlocked) begin
                        preset_next[15:8] = data_s2_reg;
                        refresh = 1'b1;
                    end
                end
                `WDT_IDX_CNT_HI: begin
                    if (unlocked) begin
                        preset_next[23:16] = data_s2_reg;
                        refresh = 1'b1;
                    end
                end
                default: begin
                    refresh = 1'b0;
                end
            endcase
        end
        rdata_next = rdata_reg;
        if (rd_s2_reg && hit_index) begin
            rdata_next = index_reg;
        end else if (rd_s2_reg && hit_data) begin
            rdata_next = read_mux(index_reg, unlock_reg, enable_reg,
                                  action_reg, preset_reg);
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            index_reg <= `WDT_RST_BYTE;
            unlock_reg <= `WDT_RST_BYTE;
            enable_reg <= `WDT_RST_BYTE;
            action_reg <= `WDT_RST_BYTE;
            preset_reg <= `WDT_RST_COUNT;
            rdata_reg <= `WDT_RST_BYTE;
        end else begin
            index_reg <= index_next;
            unlock_reg <= unlock_next;
            enable_reg <= enable_next;
            action_reg <= action_next;
            preset_reg <= preset_next;
            rdata_reg <= rdata_next;
        end
    end

    assign IO_RDATA_O = rdata_reg;
    assign IO_RDATA_OE_O = rd_s2_reg & (hit_index | hit_data);

    // -----------------------------------------------------------------------
    // Countdown
    // -----------------------------------------------------------------------
    wdt_pkg::wdt_state_e state_reg, state_next;
    logic [CW-1:0] count_reg, count_next;
    logic [CW-1:0] load_val;
    logic run_en;
    logic [3:0] act_sel;

    // A preset of zero would never expire, so it counts as one tick.
    assign load_val = (preset_reg == '0) ? CW'(1) : preset_reg;
    assign run_en = enable_reg[`WDT_ENABLE_BIT];
    assign act_sel = action_reg[`WDT_ACTION_MSB:`WDT_ACTION_LSB];

    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        case (state_reg)
            wdt_pkg::WDT_IDLE: begin
                count_next = load_val;
                if (run_en) begin
                    state_next = wdt_pkg::WDT_RUN;
                end
            end
            wdt_pkg::WDT_RUN: begin
                if (!run_en) begin
                    state_next = wdt_pkg::WDT_IDLE;
                end else if (refresh) begin
                    count_next = load_val;
                end else if (tick) begin
                    count_next = count_reg - CW'(1);
                    if (count_reg == CW'(1)) begin
                        state_next = wdt_pkg::WDT_EXPIRED;
                    end
                end
            end
            wdt_pkg::WDT_EXPIRED: begin
                if (!run_en) begin
                    state_next = wdt_pkg::WDT_IDLE;
                end else if (refresh) begin
                    count_next = load_val;
                    state_next = wdt_pkg::WDT_RUN;
                end
            end
            default: begin
                state_next = wdt_pkg::WDT_IDLE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_reg <= wdt_pkg::WDT_IDLE;
            count_reg <= `WDT_RST_COUNT;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
        end
    end

    // -----------------------------------------------------------------------
    // Time-out report
    // -----------------------------------------------------------------------
    logic rst_o_reg, irq_o_reg, nmi_o_reg;
    logic expired_next;

    assign expired_next = (state_next == wdt_pkg::WDT_EXPIRED);

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rst_o_reg <= 1'b0;
            irq_o_reg <= 1'b0;
            nmi_o_reg <= 1'b0;
        end else begin
            rst_o_reg <= expired_next & act_sel[0];
            irq_o_reg <= expired_next & act_sel[1];
            nmi_o_reg <= expired_next & act_sel[2];
        end
    end

    assign WDT_RESET_O = rst_o_reg;
    assign WDT_IRQ_O = irq_o_reg;
    assign WDT_NMI_O = nmi_o_reg;
endmodule

// ### hw/wdt_consts.svh
// Purpose: Constants of the indexed-port watchdog timer.
// Assumes: 10 MHz core clock, 10-bit I/O address decode.
// Notes: Offsets, field positions, reset values and timing counts.
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH

// ---------------------------------------------------------------------------
// I/O ports and internal indexes
// ---------------------------------------------------------------------------
`define WDT_IO_INDEX_ADDR 10'h022
`define WDT_IO_DATA_ADDR 10'h023
`define WDT_IDX_UNLOCK 8'h13
`define WDT_IDX_ENABLE 8'h37
`define WDT_IDX_ACTION 8'h38
`define WDT_IDX_CNT_LO 8'h39
`define WDT_IDX_CNT_MID 8'h3a
`define WDT_IDX_CNT_HI 8'h3b

// ---------------------------------------------------------------------------
// Fields and encodings
// ---------------------------------------------------------------------------
`define WDT_UNLOCK_BIT 0
`define WDT_ENABLE_BIT 6
`define WDT_ACTION_MSB 7
`define WDT_ACTION_LSB 4
`define WDT_ACTION_RESET 4'h1
`define WDT_ACTION_IRQ 4'h2
`define WDT_ACTION_NMI 4'h4

// ---------------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------------
`define WDT_RST_BYTE 8'h00
`define WDT_RST_COUNT 24'h00_0000

// ---------------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------------
`define WDT_CORE_CLK_HZ 10000000
`define WDT_TICK_HZ 32768
`define WDT_COUNT_WIDTH 24

`endif

// ### hw/wdt_pkg.sv
// Purpose: Types of the indexed-port watchdog timer.
// Assumes: Constants come from the consts header.
// Notes: Gray-coded state along idle, run, expired.
package wdt_pkg;
    typedef enum logic [1:0] {
        WDT_IDLE = 2'b00,
        WDT_RUN = 2'b01,
        WDT_EXPIRED = 2'b11
    } wdt_state_e;
endpackage

// ### hw/wdt_tick_gen.sv
// Purpose: Fractional divider giving a 32.768 kHz one-cycle enable.
// Assumes: CLK_HZ is well above TICK_HZ.
// Notes: Phase accumulator, so the average rate is exact.
`timescale 1ns/1ps
module wdt_tick_gen #(
    parameter int CLK_HZ = 10000000,
    parameter int TICK_HZ = 32768
) (
    input wire logic clk_i, // Core clock
    input wire logic rst_n_i, // Async reset, active low
    output logic tick_o // One-cycle tick enable
);
    localparam logic [24:0] STEP = 25'(TICK_HZ);
    localparam logic [24:0] WRAP = 25'(CLK_HZ);

    logic [24:0] acc_reg;
    logic [24:0] acc_next;
    logic tick_reg;
    logic tick_next;
    logic [24:0] sum;

    always_comb begin
        sum = acc_reg + STEP;
        tick_next = 1'b0;
        acc_next = sum;
        if (sum >= WRAP) begin
            acc_next = sum - WRAP;
            tick_next = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_reg <= 25'h000_0000;
            tick_reg <= 1'b0;
        end else begin
            acc_reg <= acc_next;
            tick_reg <= tick_next;
        end
    end

    assign tick_o = tick_reg;
endmodule

// ### dv/wdt_top_assertions.sv
// Purpose: Port checks of the indexed-port watchdog.
// Assumes: Host strobes stay low and high four clocks or more.
// Notes: Bound into wdt_top; watches its ports only.
`timescale 1ns/1ps
`include "wdt_consts.svh"
module wdt_top_chk (
    input wire logic CORE_CLK_I, // Core clock
    input wire logic RST_N_I, // Reset, active low
    input wire logic [9:0] IO_ADDR_I, // I/O address
    input wire logic IO_WR_N_I, // Write strobe
    input wire logic IO_RD_N_I, // Read strobe
    input wire logic [7:0] IO_RDATA_O, // Read data
    input wire logic IO_RDATA_OE_O, // Read data enable
    input wire logic WDT_RESET_O, // Reset request
    input wire logic WDT_IRQ_O, // Interrupt request
    input wire logic WDT_NMI_O // NMI request
);
    // ---------------------------------------------------------------
    // Port properties
    // ---------------------------------------------------------------
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_N_I);
    logic hit;
    assign hit = (IO_ADDR_I == `WDT_IO_INDEX_ADDR) ||
        (IO_ADDR_I == `WDT_IO_DATA_ADDR);
    sequence rd_start;
        $fell(IO_RD_N_I) && hit;
    endsequence
    // A write acts only inside its strobe, so four quiet cycles mean no
    // refresh is pending that could drop a time-out output.
    sequence wr_quiet;
        IO_WR_N_I [*4];
    endsequence
    rd_oe_on_a: assert property (
        rd_start |-> ##[1:3] IO_RDATA_OE_O) else $error("late read enable");
    rd_oe_hold_a: assert property (
        IO_RDATA_OE_O && !IO_RD_N_I |=> IO_RDATA_OE_O)
        else $error("read enable lost");
    rd_oe_off_a: assert property (
        IO_RD_N_I [*4] |-> !IO_RDATA_OE_O) else $error("read enable stuck");
    oe_addr_a: assert property (
        IO_RDATA_OE_O |-> hit) else $error("enable on foreign address");
    rdata_hold_a: assert property (
        IO_RD_N_I [*4] |=> $stable(IO_RDATA_O))
        else $error("read data moved");
    rst_hold_a: assert property (
        wr_quiet ##0 WDT_RESET_O |=> WDT_RESET_O) else $error("reset dropped");
    irq_hold_a: assert property (
        wr_quiet ##0 WDT_IRQ_O |=> WDT_IRQ_O) else $error("irq dropped");
    nmi_hold_a: assert property (
        wr_quiet ##0 WDT_NMI_O |=> WDT_NMI_O) else $error("nmi dropped");
endmodule
bind wdt_top wdt_top_chk u_chk (.CORE_CLK_I, .RST_N_I, .IO_ADDR_I,
    .IO_WR_N_I, .IO_RD_N_I, .IO_RDATA_O, .IO_RDATA_OE_O, .WDT_RESET_O,
    .WDT_IRQ_O, .WDT_NMI_O);

// ### dv/tb_wdt_top.sv
// Purpose: Self-checking bench of the indexed-port watchdog.
// Assumes: TICK_HZ raised so one tick is ten core clocks.
// Notes: Host cycles are slow because strobes pass synchronisers.
`timescale 1ns/1ps
`include "wdt_consts.svh"
module tb_wdt_top;
    localparam int TK = 10;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [9:0] addr = 10'h000;
    logic [7:0] wdata = 8'h00;
    logic wr_n = 1'b1;
    logic rd_n = 1'b1;
    logic [7:0] rdata;
    logic [7:0] got_d;
    logic oe;
    logic got_oe;
    logic o_rst;
    logic o_irq;
    logic o_nmi;
    logic [7:0] outs;
    logic [31:0] seed = 32'h0000_0022;
    int n_errors = 0;
    int checks = 0;
    assign outs = {5'h00, o_nmi, o_irq, o_rst};
    always #50 clk = ~clk;
    wdt_top #(.TICK_HZ(1000000)) u_dut (.CORE_CLK_I(clk), .RST_N_I(rst_n),
        .IO_ADDR_I(addr), .IO_WDATA_I(wdata), .IO_WR_N_I(wr_n),
        .IO_RD_N_I(rd_n), .IO_RDATA_O(rdata), .IO_RDATA_OE_O(oe),
        .WDT_RESET_O(o_rst), .WDT_IRQ_O(o_irq), .WDT_NMI_O(o_nmi));
    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [7:0] act_out(input logic [7:0] a);
        return {5'h00, |(a[7:4] & `WDT_ACTION_NMI),
            |(a[7:4] & `WDT_ACTION_IRQ), |(a[7:4] & `WDT_ACTION_RESET)};
    endfunction
    task automatic chk(input string w, input logic [7:0] e,
        input logic [7:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic end_of_test();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Address and data settle two clocks ahead, as the synchronisers need.
    task automatic io(input logic [9:0] a, input logic [7:0] d,
        input logic rd);
        addr = a;
        wdata = d;
        cyc(2);
        rd_n = !rd;
        wr_n = rd;
        cyc(6);
        got_d = rdata;
        got_oe = oe;
        rd_n = 1'b1;
        wr_n = 1'b1;
        cyc(6);
    endtask
    task automatic wreg(input logic [7:0] i, input logic [7:0] v);
        io(`WDT_IO_INDEX_ADDR, i, 1'b0);
        io(`WDT_IO_DATA_ADDR, v, 1'b0);
    endtask
    task automatic rreg(input string w, input logic [7:0] i,
        input logic [7:0] e);
        io(`WDT_IO_INDEX_ADDR, i, 1'b0);
        io(`WDT_IO_DATA_ADDR, 8'h00, 1'b1);
        chk(w, e, got_d);
    endtask
    task automatic expire(input logic [7:0] n, input logic [7:0] a);
        int t;
        int nn;
        nn = (n == 8'h00) ? 1 : int'(n);
        wreg(`WDT_IDX_CNT_LO, n);
        wreg(`WDT_IDX_CNT_MID, 8'h00);
        wreg(`WDT_IDX_CNT_HI, 8'h00);
        wreg(`WDT_IDX_ACTION, a);
        wreg(`WDT_IDX_ENABLE, 8'h40);
        t = 9;
        while (outs == 8'h00 && t < nn * TK + 4) begin
            cyc(1);
            t++;
        end
        chk("action", act_out(a), outs);
        chk("early", 8'h01, {7'h00, t >= (nn - 1) * TK});
        io(`WDT_IO_DATA_ADDR, 8'h40, 1'b0);
        if (nn > 1)
            chk("refresh", 8'h00, outs);
        io(`WDT_IO_DATA_ADDR, 8'h00, 1'b0);
        chk("disable", 8'h00, outs);
    endtask
    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    localparam logic [7:0] IDX [6] = '{`WDT_IDX_UNLOCK, `WDT_IDX_ENABLE,
        `WDT_IDX_ACTION, `WDT_IDX_CNT_LO, `WDT_IDX_CNT_MID, `WDT_IDX_CNT_HI};
    initial begin
        cyc(5);
        rst_n = 1'b1;
        cyc(1);
        foreach (IDX[i]) rreg("reset", IDX[i], 8'h00);
        wreg(`WDT_IDX_ENABLE, 8'h40);
        wreg(`WDT_IDX_CNT_LO, 8'h5a);
        rreg("locked enable", `WDT_IDX_ENABLE, 8'h00);
        rreg("locked count", `WDT_IDX_CNT_LO, 8'h00);
        chk("locked out", 8'h00, outs);
        wreg(`WDT_IDX_UNLOCK, 8'h01);
        rreg("unlock", `WDT_IDX_UNLOCK, 8'h01);
        io(`WDT_IO_INDEX_ADDR, 8'h3a, 1'b0);
        io(`WDT_IO_INDEX_ADDR, 8'h00, 1'b1);
        chk("index", 8'h3a, got_d);
        wreg(8'h40, 8'hff);
        rreg("unmapped", 8'h40, 8'h00);
        io(10'h024, 8'h00, 1'b1);
        chk("foreign enable", 8'h00, {7'h00, got_oe});
        for (int i = 3; i < 6; i++) begin
            seed = xs(seed);
            wreg(IDX[i], seed[7:0]);
            rreg("count byte", IDX[i], seed[7:0]);
            wreg(IDX[i], 8'hff);
            rreg("count max", IDX[i], 8'hff);
        end
        wreg(`WDT_IDX_ACTION, 8'h20);
        wreg(`WDT_IDX_CNT_LO, 8'h04);
        wreg(`WDT_IDX_CNT_MID, 8'h00);
        wreg(`WDT_IDX_CNT_HI, 8'h00);
        wreg(`WDT_IDX_ENABLE, 8'h40);
        io(`WDT_IO_INDEX_ADDR, `WDT_IDX_CNT_LO, 1'b0);
        repeat (8) begin
            io(`WDT_IO_DATA_ADDR, 8'h04, 1'b0);
            chk("kept alive", 8'h00, outs);
        end
        for (int i = 0; i < 3; i++) expire(8'h03, 8'h10 << i);
        repeat (4) begin
            seed = xs(seed);
            expire({6'h00, seed[1:0]},
                {1'b0, (seed[6:4] == 3'h0) ? 3'h1 : seed[6:4], 4'h0});
        end
        // A system reset in mid-run must drop a standing time-out.
        wreg(`WDT_IDX_ENABLE, 8'h40);
        cyc(30);
        chk("armed", 8'h01, {7'h00, outs != 8'h00});
        rst_n = 1'b0;
        cyc(5);
        chk("reset out", 8'h00, outs);
        rst_n = 1'b1;
        cyc(1);
        rreg("reset unlock", `WDT_IDX_UNLOCK, 8'h00);
        rreg("reset enable", `WDT_IDX_ENABLE, 8'h00);
        end_of_test();
    end
    initial begin
        #2000000;
        n_errors++;
        end_of_test();
    end
endmodule
